// [pkg/irl_pkg.sv]
// Shared constants and types of the interrupt request logic.
// Assumes one clock domain and a core that vectors on a presented request.
package irl_pkg;

  // Number of request sources and width of a source index.
  localparam int unsigned NUM_SRC = 10;
  localparam int unsigned SRC_W = 4;

  // Source indices, which are also the polling order, 0 highest.
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_UART2 = 4'h1;
  localparam logic [3:0] SRC_T0 = 4'h2;
  localparam logic [3:0] SRC_TWI = 4'h3;
  localparam logic [3:0] SRC_EXT1 = 4'h4;
  localparam logic [3:0] SRC_DDC = 4'h5;
  localparam logic [3:0] SRC_T1 = 4'h6;
  localparam logic [3:0] SRC_USB = 4'h7;
  localparam logic [3:0] SRC_UART1 = 4'h8;
  localparam logic [3:0] SRC_T2 = 4'h9;

  // USB event bit positions inside the USB flag vector.
  localparam int unsigned USB_EVT_W = 7;
  localparam int unsigned USB_EP0_TX = 0;
  localparam int unsigned USB_EP0_RX = 1;
  localparam int unsigned USB_EP1_TX = 2;
  localparam int unsigned USB_EP2_TX = 3;
  localparam int unsigned USB_SUSPEND = 4;
  localparam int unsigned USB_RESUME = 5;
  localparam int unsigned USB_EOP = 6;

  // Service level state: none, low, high, or high nested over low.
  typedef enum logic [3:0] {
    IRL_SVC_NONE = 4'h1,
    IRL_SVC_LOW = 4'h2,
    IRL_SVC_HIGH = 4'h4,
    IRL_SVC_NEST = 4'h8
  } irl_svc_type;

  // Request presented to the core.
  typedef struct packed {
    logic req;
    logic high;
    logic [3:0] src;
  } irl_core_type;

  // Whole state of the top module.
  typedef struct packed {
    logic pin0_q;
    logic pin1_q;
    logic t2_in_q;
    logic ext0_flag;
    logic ext1_flag;
    logic t0_flag;
    logic t1_flag;
    logic t2_flag;
    logic t2ext_flag;
    logic twi_flag;
    logic ddc2b_flag;
    logic ddc1_flag;
    logic swh_flag;
    logic [6:0] usb_flags;
    irl_svc_type svc;
    irl_core_type core;
  } irl_state_type;

  // Value of the state after reset.
  localparam irl_state_type STATE_RESET = '{
    pin0_q: 1'b0, pin1_q: 1'b0, t2_in_q: 1'b1,
    ext0_flag: 1'b0, ext1_flag: 1'b0, t0_flag: 1'b0, t1_flag: 1'b0,
    t2_flag: 1'b0, t2ext_flag: 1'b0, twi_flag: 1'b0, ddc2b_flag: 1'b0,
    ddc1_flag: 1'b0, swh_flag: 1'b0, usb_flags: 7'h00,
    svc: IRL_SVC_NONE, core: '{req: 1'b0, high: 1'b0, src: 4'h0}
  };

endpackage : irl_pkg

// [design/irl_arbiter.sv]
// Priority arbiter choosing one enabled request for the core.
// Assumes candidates are already gated by enables; purely combinational.
module irl_arbiter #(
  parameter int unsigned N = 10
) (
  input wire logic [N-1:0] cand,
  input wire logic [N-1:0] prio,
  input irl_pkg::irl_svc_type svc,
  output logic win,
  output logic win_high,
  output logic [3:0] win_src
);

  // Returns the lowest set index, which is the earliest in polling order.
  function automatic logic [3:0] first_set(input logic [N-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : first_set

  logic [N-1:0] hi_cand;
  logic [N-1:0] lo_cand;

  // High requests beat low ones; a running high routine blocks all, a running
  // low routine admits only high requests.
  always_comb begin
    hi_cand = cand & prio;
    lo_cand = cand & ~prio;
    win = 1'b0;
    win_high = 1'b0;
    win_src = 4'h0;
    if (svc == irl_pkg::IRL_SVC_HIGH || svc == irl_pkg::IRL_SVC_NEST) begin
      win = 1'b0;
    end else if (|hi_cand) begin
      win = 1'b1;
      win_high = 1'b1;
      win_src = first_set(hi_cand);
    end else if (|lo_cand && svc == irl_pkg::IRL_SVC_NONE) begin
      win = 1'b1;
      win_src = first_set(lo_cand);
    end
  end

endmodule : irl_arbiter

// [design/irl_top.sv]
// Interrupt request logic: request flags for ten sources, enables,
// two priority levels and presentation of one request to the core.
// Assumes all inputs synchronous to mclk; pulses last one cycle.
// What this block does
// - Ten request sources feed the arbiter
// - First pin level or edge sensed
// - Second pin level or edge sensed
// - Edge flags clear on vector taken
// - Level flag follows active pin
// - Converter completion may drive second pin
// - Timers 0,1 set overflow flags; mode 3
// - Timer 0,1 flags clear when serviced
// - Timer 2 flag cleared only by software
// - Timer 2 external edge also requests
// - Two-wire flag cleared by hardware
// - Display request from three flags
// - Only display status flag hardware cleared
// - USB events raise USB request
// - USB flags cleared only by software
// - Individual enables gated by global enable
// - High preempts low, nothing preempts high
// - Fixed polling order within a level
// - Global enable clear blocks acknowledge
module irl_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic ext_irq_pin_first_n,
  input wire logic ext_irq_pin_second_n,
  input wire logic first_ext_sense_select,
  input wire logic second_ext_sense_select,
  input wire logic adc_takeover,
  input wire logic adc_done,
  input wire logic timer0_ovf,
  input wire logic timer0_mode3,
  input wire logic timer0_low_ovf,
  input wire logic timer0_high_ovf,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  input wire logic timer_two_overflow_clr,
  input wire logic timer_two_external_input,
  input wire logic timer_two_external_enable,
  input wire logic timer_two_external_clr,
  input wire logic uart1_req,
  input wire logic uart2_req,
  input wire logic twowire_intr_set,
  input wire logic ddc2b_intr_set,
  input wire logic ddc1_intr_set,
  input wire logic ddc1_intr_clr,
  input wire logic protocol_switch_set,
  input wire logic protocol_switch_clr,
  input wire logic [6:0] usb_evt,
  input wire logic [6:0] usb_clr,
  input wire logic global_irq_enable,
  input wire logic [9:0] irq_enable,
  input wire logic [9:0] irq_priority,
  input wire logic irq_ack,
  input wire logic irq_reti,
  output logic irq_req,
  output irl_pkg::irl_core_type irq_core,
  output irl_pkg::irl_svc_type irq_svc,
  output logic first_ext_request_flag,
  output logic second_ext_request_flag,
  output logic timer_zero_overflow_flag,
  output logic timer_one_overflow_flag,
  output logic timer_two_overflow_flag,
  output logic timer_two_external_flag,
  output logic twowire_intr_flag,
  output logic ddc2b_intr_flag,
  output logic ddc1_intr_flag,
  output logic protocol_switch_flag,
  output logic [6:0] usb_flags
);

  irl_pkg::irl_state_type s_q;
  irl_pkg::irl_state_type s_d;
  logic [9:0] pending;
  logic [9:0] cand;
  logic win;
  logic win_high;
  logic [3:0] win_src;
  logic ack_ok;
  logic pin0_act;
  logic pin1_act;
  logic edge0;
  logic edge1;
  logic ext1_evt;
  logic t0_set;
  logic t1_set;
  logic t2_fall;

  // Acknowledge counts only against a presented request while enabled.
  function automatic logic acked(input irl_pkg::irl_state_type s, input logic ok, input logic [3:0] src);
    return ok && s.core.src == src;
  endfunction : acked

  // Pending vector in polling order and its gating by the enables.
  always_comb begin
    pending[irl_pkg::SRC_EXT0] = s_q.ext0_flag;
    pending[irl_pkg::SRC_UART2] = uart2_req;
    pending[irl_pkg::SRC_T0] = s_q.t0_flag;
    pending[irl_pkg::SRC_TWI] = s_q.twi_flag;
    pending[irl_pkg::SRC_EXT1] = s_q.ext1_flag;
    pending[irl_pkg::SRC_DDC] = s_q.ddc2b_flag | s_q.ddc1_flag | s_q.swh_flag;
    pending[irl_pkg::SRC_T1] = s_q.t1_flag;
    pending[irl_pkg::SRC_USB] = |s_q.usb_flags;
    pending[irl_pkg::SRC_UART1] = uart1_req;
    pending[irl_pkg::SRC_T2] = s_q.t2_flag | s_q.t2ext_flag;
    cand = pending & irq_enable & {irl_pkg::NUM_SRC{global_irq_enable}};
  end

  // Arbiter picks the winner for the next presentation.
  irl_arbiter #(
    .N(irl_pkg::NUM_SRC)
  ) u_arb (
    .cand(cand),
    .prio(irq_priority),
    .svc(s_q.svc),
    .win(win),
    .win_high(win_high),
    .win_src(win_src)
  );

  // Next state: flag set and clear, service level, presentation.
  always_comb begin
    s_d = s_q;
    ack_ok = irq_ack && s_q.core.req && global_irq_enable;
    pin0_act = ~ext_irq_pin_first_n;
    pin1_act = ~ext_irq_pin_second_n;
    edge0 = pin0_act && !s_q.pin0_q;
    edge1 = pin1_act && !s_q.pin1_q;
    ext1_evt = adc_takeover ? adc_done : edge1;
    t0_set = timer0_mode3 ? timer0_low_ovf : timer0_ovf;
    t1_set = timer0_mode3 ? timer0_high_ovf : timer1_ovf;
    t2_fall = s_q.t2_in_q && !timer_two_external_input;
    s_d.pin0_q = pin0_act;
    s_d.pin1_q = pin1_act;
    s_d.t2_in_q = timer_two_external_input;
    // External flags: edge mode sets on a falling pin, level mode follows it.
    if (first_ext_sense_select) begin
      s_d.ext0_flag = edge0 || (s_q.ext0_flag && !acked(s_q, ack_ok, irl_pkg::SRC_EXT0));
    end else begin
      s_d.ext0_flag = pin0_act;
    end
    if (second_ext_sense_select || adc_takeover) begin
      s_d.ext1_flag = ext1_evt || (s_q.ext1_flag && !acked(s_q, ack_ok, irl_pkg::SRC_EXT1));
    end else begin
      s_d.ext1_flag = pin1_act;
    end
    // Timer flags; a new set in the clearing cycle wins.
    s_d.t0_flag = t0_set || (s_q.t0_flag && !acked(s_q, ack_ok, irl_pkg::SRC_T0));
    s_d.t1_flag = t1_set || (s_q.t1_flag && !acked(s_q, ack_ok, irl_pkg::SRC_T1));
    s_d.t2_flag = timer2_ovf || (s_q.t2_flag && !timer_two_overflow_clr);
    s_d.t2ext_flag = (t2_fall && timer_two_external_enable)
                     || (s_q.t2ext_flag && !timer_two_external_clr);
    // Two-wire and display flags.
    s_d.twi_flag = twowire_intr_set || (s_q.twi_flag && !acked(s_q, ack_ok, irl_pkg::SRC_TWI));
    s_d.ddc2b_flag = ddc2b_intr_set || (s_q.ddc2b_flag && !acked(s_q, ack_ok, irl_pkg::SRC_DDC));
    s_d.ddc1_flag = ddc1_intr_set || (s_q.ddc1_flag && !ddc1_intr_clr);
    s_d.swh_flag = protocol_switch_set || (s_q.swh_flag && !protocol_switch_clr);
    s_d.usb_flags = usb_evt | (s_q.usb_flags & ~usb_clr);
    // Service level: acknowledge enters a level, return leaves the top one.
    if (ack_ok) begin
      case (s_q.svc)
        irl_pkg::IRL_SVC_NONE: begin
          s_d.svc = s_q.core.high ? irl_pkg::IRL_SVC_HIGH : irl_pkg::IRL_SVC_LOW;
        end
        irl_pkg::IRL_SVC_LOW: begin
          s_d.svc = irl_pkg::IRL_SVC_NEST;
        end
        default: begin
          s_d.svc = s_q.svc;
        end
      endcase
    end else if (irq_reti) begin
      case (s_q.svc)
        irl_pkg::IRL_SVC_NEST: begin
          s_d.svc = irl_pkg::IRL_SVC_LOW;
        end
        default: begin
          s_d.svc = irl_pkg::IRL_SVC_NONE;
        end
      endcase
    end
    // Presentation drops for the cycle after an acknowledge so the cleared
    // flags and new level are seen before the next choice.
    s_d.core.req = win && !ack_ok;
    s_d.core.high = win_high && !ack_ok;
    s_d.core.src = ack_ok ? 4'h0 : win_src;
  end

  // State register.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= irl_pkg::STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs; request handshake is gated by the global enable.
  assign irq_req = s_q.core.req && global_irq_enable;
  assign irq_core = s_q.core;
  assign irq_svc = s_q.svc;
  assign first_ext_request_flag = s_q.ext0_flag;
  assign second_ext_request_flag = s_q.ext1_flag;
  assign timer_zero_overflow_flag = s_q.t0_flag;
  assign timer_one_overflow_flag = s_q.t1_flag;
  assign timer_two_overflow_flag = s_q.t2_flag;
  assign timer_two_external_flag = s_q.t2ext_flag;
  assign twowire_intr_flag = s_q.twi_flag;
  assign ddc2b_intr_flag = s_q.ddc2b_flag;
  assign ddc1_intr_flag = s_q.ddc1_flag;
  assign protocol_switch_flag = s_q.swh_flag;
  assign usb_flags = s_q.usb_flags;

  // Checks of flag behaviour and presentation.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  edge_ext0_a: assert property (first_ext_sense_select && irq_req && irq_ack && irq_core.src == 4'h0
    && !(~ext_irq_pin_first_n && !s_q.pin0_q) |=> !first_ext_request_flag)
    else $error("edge flag of first pin not cleared on acknowledge");
  level_ext0_a: assert property (!first_ext_sense_select && !ext_irq_pin_first_n [*2]
    |-> first_ext_request_flag)
    else $error("level flag of first pin not following the pin");
  adc_take_a: assert property (adc_takeover && adc_done |=> second_ext_request_flag)
    else $error("converter completion did not raise second request");
  t0_set_a: assert property (!timer0_mode3 && timer0_ovf |=> timer_zero_overflow_flag)
    else $error("timer 0 overflow flag not set");
  t2_hold_a: assert property (timer_two_overflow_flag && !timer_two_overflow_clr
    |=> timer_two_overflow_flag)
    else $error("timer 2 flag cleared without software");
  t2_edge_a: assert property (timer_two_external_enable && $fell(timer_two_external_input)
    |=> timer_two_external_flag)
    else $error("timer 2 external edge not recorded");
  twi_clear_a: assert property (irq_req && irq_ack && irq_core.src == 4'h3 && !twowire_intr_set
    |=> !twowire_intr_flag)
    else $error("two-wire flag not cleared on acknowledge");
  ddc_hold_a: assert property (ddc1_intr_flag && !ddc1_intr_clr |=> ddc1_intr_flag)
    else $error("display flag cleared without software");
  usb_hold_a: assert property (usb_flags[0] && !usb_clr[0] |=> usb_flags[0])
    else $error("USB flag cleared without software");
  global_off_a: assert property (!global_irq_enable |=> !irq_core.req)
    else $error("request presented while globally disabled");
  high_block_a: assert property (irq_svc == irl_pkg::IRL_SVC_HIGH ##1 !irq_ack
    |-> !irq_core.req)
    else $error("request presented during high routine");
  ack_gap_a: assert property (irq_req && irq_ack |=> !irq_core.req)
    else $error("presentation not dropped after acknowledge");

  nest_c: cover property (irq_svc == irl_pkg::IRL_SVC_NEST);
  ack_c: cover property (irq_req && irq_ack ##[1:20] irq_reti);
  usb_c: cover property (irq_req && irq_core.src == 4'h7);
  t2_edge_c: cover property (irq_req && irq_core.src == 4'h9 && timer_two_external_flag);

endmodule : irl_top

// [testbench/irl_core_model.sv]
// Core model that vectors to the presented request and returns after a fixed routine.
// Assumes the request logic presents registered outputs on the rising edge of mclk.
module irl_core_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic irq_req,
  input irl_pkg::irl_core_type irq_core,
  input wire logic run,
  input wire logic [3:0] lag,
  output logic mdl_ack,
  output logic mdl_reti,
  output logic [3:0] taken
);
  timeunit 1ns;
  timeprecision 1ns;

  logic busy_q;
  logic [3:0] wait_q;
  logic [3:0] body_q;

  // Acks a request that has stood for lag+1 cycles, then returns eight cycles later.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {busy_q, wait_q, body_q, mdl_ack, mdl_reti, taken} <= '0;
    end else begin
      mdl_ack <= 1'b0;
      mdl_reti <= 1'b0;
      if (busy_q) begin
        body_q <= body_q + 4'h1;
        busy_q <= body_q != 4'h7;
        mdl_reti <= body_q == 4'h7;
      end else if (run && irq_req) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q == lag) begin
          {mdl_ack, busy_q, wait_q, body_q} <= {2'h3, 8'h00};
          taken <= irq_core.src;
        end
      end else begin
        wait_q <= 4'h0;
      end
    end
  end
endmodule : irl_core_model

// [testbench/tb_top.sv]
// Self-checking bench of the interrupt request logic, served by the core model.
// Assumes all design inputs are sampled on the rising edge of mclk.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk, rst, ext_irq_pin_first_n, ext_irq_pin_second_n, first_ext_sense_select, second_ext_sense_select;
  logic adc_takeover, adc_done, timer0_ovf, timer0_mode3, timer0_low_ovf, timer0_high_ovf, timer1_ovf;
  logic timer2_ovf, timer_two_overflow_clr, timer_two_external_input, timer_two_external_enable;
  logic timer_two_external_clr, uart1_req, uart2_req, twowire_intr_set, ddc2b_intr_set, ddc1_intr_set;
  logic ddc1_intr_clr, protocol_switch_set, protocol_switch_clr, global_irq_enable, irq_ack, irq_reti;
  logic irq_req, first_ext_request_flag, second_ext_request_flag, timer_zero_overflow_flag;
  logic timer_one_overflow_flag, timer_two_overflow_flag, timer_two_external_flag, twowire_intr_flag;
  logic ddc2b_intr_flag, ddc1_intr_flag, protocol_switch_flag, run, man_ack, man_reti, mdl_ack, mdl_reti;
  logic [6:0] usb_evt, usb_clr, usb_flags;
  logic [9:0] irq_enable, irq_priority, fv;
  logic [3:0] lag, taken;
  irl_pkg::irl_core_type irq_core;
  irl_pkg::irl_svc_type irq_svc;
  int fails = 0;
  int checks_done = 0;
  logic [4:0] rows [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h17, 5'h08, 5'h19};

  irl_top dut (.*);
  irl_core_model mdl (.*);

  // Clock, acknowledge source selection and a flag view indexed by polling order.
  always #5 mclk = ~mclk;
  assign irq_ack = run ? mdl_ack : man_ack;
  assign irq_reti = run ? mdl_reti : man_reti;
  assign fv = {timer_two_overflow_flag, 1'b0, |usb_flags, timer_one_overflow_flag, ddc2b_intr_flag,
    second_ext_request_flag, twowire_intr_flag, timer_zero_overflow_flag, 1'b0, first_ext_request_flag};

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic at(input int n);
    repeat (n) @(posedge mclk);
  endtask : at

  // Waits a bounded time for the core model to vector.
  task automatic wack;
    int i;
    for (i = 0; i < 60; i++) begin
      @(posedge mclk);
      #1;
      if (irq_ack === 1'b1) break;
    end
    if (i == 60) begin
      fails++;
      complete_run;
    end
  endtask : wack

  task automatic serve(input int n);
    repeat (n) begin
      wack;
      at(4);
    end
  endtask : serve

  // Raises one source for a single cycle; serial requests stay up until cleared.
  task automatic fire(input logic [3:0] s);
    @(posedge mclk);
    case (s)
      4'h0: ext_irq_pin_first_n <= 1'b0;
      4'h1: uart2_req <= 1'b1;
      4'h2: timer0_ovf <= 1'b1;
      4'h3: twowire_intr_set <= 1'b1;
      4'h4: ext_irq_pin_second_n <= 1'b0;
      4'h5: ddc2b_intr_set <= 1'b1;
      4'h6: timer1_ovf <= 1'b1;
      4'h7: usb_evt <= 7'h40;
      4'h8: uart1_req <= 1'b1;
      default: timer2_ovf <= 1'b1;
    endcase
    @(posedge mclk);
    {ext_irq_pin_first_n, ext_irq_pin_second_n} <= 2'h3;
    {timer0_ovf, twowire_intr_set, ddc2b_intr_set, timer1_ovf, timer2_ovf} <= 5'h00;
    usb_evt <= 7'h00;
  endtask : fire

  // Service software clears every flag it owns.
  task automatic clr_sw;
    @(posedge mclk);
    {uart1_req, uart2_req} <= 2'h0;
    usb_clr <= 7'h7f;
    {timer_two_overflow_clr, timer_two_external_clr, ddc1_intr_clr, protocol_switch_clr} <= 4'hf;
    @(posedge mclk);
    usb_clr <= 7'h00;
    {timer_two_overflow_clr, timer_two_external_clr, ddc1_intr_clr, protocol_switch_clr} <= 4'h0;
  endtask : clr_sw

  // Manual acknowledge and return pulses while the core model is off.
  task automatic mack;
    at(1);
    man_ack <= 1'b1;
    at(1);
    man_ack <= 1'b0;
    #1;
  endtask : mack

  task automatic mreti;
    at(1);
    man_reti <= 1'b1;
    at(1);
    man_reti <= 1'b0;
    #1;
  endtask : mreti

  // Main sequence: reset, table of sources, then the awkward cases.
  initial begin
    mclk = 1'b0;
    {adc_takeover, adc_done, timer0_ovf, timer0_mode3, timer0_low_ovf, timer0_high_ovf, timer1_ovf, timer2_ovf,
      timer_two_overflow_clr, timer_two_external_enable, timer_two_external_clr, uart1_req, uart2_req,
      twowire_intr_set, ddc2b_intr_set, ddc1_intr_set, ddc1_intr_clr, protocol_switch_set, protocol_switch_clr,
      man_ack, man_reti, irq_priority, usb_evt, usb_clr, lag} <= '0;
    {rst, ext_irq_pin_first_n, ext_irq_pin_second_n, timer_two_external_input, first_ext_sense_select,
      second_ext_sense_select, run, global_irq_enable} <= '1;
    irq_enable <= 10'h3ff;
    at(8);
    #1 chk({irq_svc, irq_req, fv, usb_flags}, {irl_pkg::IRL_SVC_NONE, 1'b0, 17'h0});
    at(8);
    rst <= 1'b0;
    $display("reset test done");
    foreach (rows[r]) begin
      @(posedge mclk);
      lag <= 4'(r % 4);
      fire(rows[r][3:0]);
      wack;
      chk(taken, 16'(rows[r][3:0]));
      at(1);
      #1 chk(fv[rows[r][3:0]], rows[r][4]);
      clr_sw;
      at(12);
      $display("case %0d done", r);
    end
    // Global and individual enables hold a standing flag back.
    @(posedge mclk);
    global_irq_enable <= 1'b0;
    fire(2);
    at(3);
    #1 chk({irq_req, fv[2]}, 2'h1);
    @(posedge mclk);
    global_irq_enable <= 1'b1;
    irq_enable <= 10'h3fb;
    at(3);
    #1 chk(irq_req, 1'b0);
    @(posedge mclk);
    irq_enable <= 10'h3ff;
    serve(1);
    $display("enable test done");
    // Simultaneous requests at equal and at different levels.
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk);
      global_irq_enable <= 1'b0;
      irq_priority <= k ? 10'h200 : 10'h000;
      fire(9);
      fire(0);
      @(posedge mclk);
      global_irq_enable <= 1'b1;
      wack;
      chk(taken, k ? 4'h9 : 4'h0);
      if (k) clr_sw;
      at(4);
      wack;
      chk(taken, k ? 4'h0 : 4'h9);
      clr_sw;
      at(12);
    end
    $display("priority test done");
    // Level sensed pin: the flag outlives the acknowledge while the pin is held.
    @(posedge mclk);
    irq_priority <= 10'h000;
    first_ext_sense_select <= 1'b0;
    ext_irq_pin_first_n <= 1'b0;
    wack;
    at(1);
    #1 chk(fv[0], 1'b1);
    @(posedge mclk);
    ext_irq_pin_first_n <= 1'b1;
    at(2);
    #1 chk(fv[0], 1'b0);
    @(posedge mclk);
    first_ext_sense_select <= 1'b1;
    at(12);
    $display("level test done");
    // Timer 0 in mode 3, timer 2 external edge and converter takeover.
    @(posedge mclk);
    global_irq_enable <= 1'b0;
    timer0_mode3 <= 1'b1;
    {timer0_ovf, timer1_ovf} <= 2'h3;
    @(posedge mclk);
    {timer0_ovf, timer1_ovf} <= 2'h0;
    {timer0_low_ovf, timer0_high_ovf} <= 2'h3;
    #1 chk({fv[6], fv[2]}, 2'h0);
    @(posedge mclk);
    {timer0_low_ovf, timer0_high_ovf} <= 2'h0;
    #1 chk({fv[6], fv[2]}, 2'h3);
    @(posedge mclk);
    timer0_mode3 <= 1'b0;
    timer_two_external_input <= 1'b0;
    @(posedge mclk);
    timer_two_external_input <= 1'b1;
    at(2);
    #1 chk(timer_two_external_flag, 1'b0);
    @(posedge mclk);
    timer_two_external_enable <= 1'b1;
    timer_two_external_input <= 1'b0;
    @(posedge mclk);
    timer_two_external_input <= 1'b1;
    adc_takeover <= 1'b1;
    adc_done <= 1'b1;
    @(posedge mclk);
    adc_done <= 1'b0;
    at(1);
    #1 chk({timer_two_external_flag, fv[4]}, 2'h3);
    @(posedge mclk);
    global_irq_enable <= 1'b1;
    serve(3);
    #1 chk(fv[4], 1'b0);
    wack;
    chk(taken, 4'h9);
    clr_sw;
    at(12);
    $display("timer test done");
    // Display flags other than the status flag wait for software.
    for (int k = 1; k < 3; k++) begin
      @(posedge mclk);
      {ddc1_intr_set, protocol_switch_set} <= 2'(k);
      @(posedge mclk);
      {ddc1_intr_set, protocol_switch_set} <= 2'h0;
      wack;
      at(1);
      #1 chk({ddc1_intr_flag, protocol_switch_flag, taken}, {2'(k), 4'h5});
      clr_sw;
      at(12);
    end
    // Every USB event sets its own flag; a set beats a clear in one cycle.
    @(posedge mclk);
    global_irq_enable <= 1'b0;
    for (int b = 0; b < 8; b++) begin
      @(posedge mclk);
      usb_evt <= (b < 7) ? 7'h01 << b : 7'h01;
      usb_clr <= (b < 7) ? 7'h00 : 7'h01;
      @(posedge mclk);
      {usb_evt, usb_clr} <= 14'h0;
      at(1);
      #1 chk(usb_flags, (b < 7) ? 7'h01 << b : 7'h01);
      clr_sw;
    end
    $display("display and usb test done");
    // Hand acknowledged nesting: refused ack, low, high over low, returns.
    @(posedge mclk);
    run <= 1'b0;
    irq_priority <= 10'h001;
    fire(2);
    at(2);
    mack;
    chk({irq_svc, fv[2]}, {irl_pkg::IRL_SVC_NONE, 1'b1});
    @(posedge mclk);
    global_irq_enable <= 1'b1;
    at(2);
    mack;
    chk(irq_svc, irl_pkg::IRL_SVC_LOW);
    fire(6);
    fire(0);
    at(2);
    #1 chk(irq_core, 6'h30);
    mack;
    chk(irq_svc, irl_pkg::IRL_SVC_NEST);
    at(3);
    #1 chk(irq_req, 1'b0);
    mreti;
    chk(irq_svc, irl_pkg::IRL_SVC_LOW);
    mreti;
    at(2);
    #1 chk(irq_core, 6'h26);
    @(posedge mclk);
    run <= 1'b1;
    serve(1);
    #1 chk(taken, 4'h6);
    $display("nesting test done");
    // Reset in mid-run clears a sticky flag and the level; a pin low at release is an edge.
    @(posedge mclk);
    timer2_ovf <= 1'b1;
    ext_irq_pin_first_n <= 1'b0;
    @(posedge mclk);
    timer2_ovf <= 1'b0;
    rst <= 1'b1;
    at(2);
    #1 chk({irq_svc, irq_core, fv, usb_flags}, {irl_pkg::IRL_SVC_NONE, 6'h00, 17'h0});
    @(posedge mclk);
    rst <= 1'b0;
    at(1);
    #1 chk(fv[0], 1'b1);
    $display("mid-run reset test done");
    complete_run;
  end
endmodule : tb_top
